// ===== rtl/spkhst_regs.vh
// Register map and field layout of the sprite plane register bank.
// Assumes a 32-bit register port addressed by byte offset.
`ifndef SPKHST_REGS_VH
`define SPKHST_REGS_VH
`define SPK_OFF_LINEAR_OFFSET  32'h0007_2184
`define SPK_OFF_STRIDE         32'h0007_2188
`define SPK_OFF_POSITION       32'h0007_218c
`define SPK_OFF_DIMENSIONS     32'h0007_2190
`define SPK_OFF_KEY_LOWER      32'h0007_2194
`define SPK_OFF_KEY_MASK       32'h0007_2198
`define SPK_OFF_SURFACE_FLIP   32'h0007_219c
`define SPK_OFF_KEY_UPPER      32'h0007_21a0
`define SPK_RESET_VALUE        32'h0000_0000
`define SPK_STRIDE_LSB         6
`define SPK_SURF_LSB           12
`define SPK_FIELD_Y_MSB        27
`define SPK_FIELD_Y_LSB        16
`define SPK_FIELD_X_MSB        11
`define SPK_FIELD_X_LSB        0
`define SPK_STRIDE_LIN_MASK    32'h0000_003f
`define SPK_STRIDE_TILE_MASK   32'h0000_00ff
`define SPK_STRIDE_TILE_MAX    32'h0000_4000
`define SPK_KEY_RGB_MASK       32'h00ff_ffff
`define SPK_KEY_CHAN_MASK      32'h0000_0007
`endif

// ===== rtl/spkhst_ctrl.v
// Host-side controller that programs one sprite plane register bank.
// Assumes the device port takes one write or read per cycle with wr/rd strobes.
`timescale 1ns/1ps
`include "spkhst_regs.vh"

module spkhst_ctrl (
   // Clock and reset
   input  wire        mclk,
   input  wire        sys_rst,
   // User order
   input  wire        cmd_start,
   output wire        cmd_ready,
   output reg         cmd_done_reg,
   output reg         cmd_error_reg,
   input  wire        cfg_tiled,
   input  wire        cfg_yuv,
   input  wire [1:0]  cfg_low_bits,
   input  wire        cfg_rotate,
   input  wire [31:0] cfg_linear_offset,
   input  wire [31:0] cfg_last_pixel_offset,
   input  wire [31:0] cfg_stride,
   input  wire [11:0] cfg_pos_x,
   input  wire [11:0] cfg_pos_y,
   input  wire [12:0] cfg_width,
   input  wire [12:0] cfg_height,
   input  wire [12:0] cfg_disp_width,
   input  wire [12:0] cfg_disp_height,
   input  wire [23:0] cfg_key_lower,
   input  wire [23:0] cfg_key_upper,
   input  wire [2:0]  cfg_key_mask,
   input  wire [31:0] cfg_surface_base,
   // Readback order
   input  wire        rb_start,
   input  wire [31:0] rb_addr,
   output reg  [31:0] rb_data_reg,
   output reg         rb_valid_reg,
   // Device register port
   output reg  [31:0] dev_addr_reg,
   output reg  [31:0] dev_wdata_reg,
   output reg         dev_wr_reg,
   output reg         dev_rd_reg,
   input  wire [31:0] dev_rdata
);

////////////////////////////////////////////////////////////////////////////////
localparam [10:0] ST_IDLE   = 11'h001;
localparam [10:0] ST_LINOFF = 11'h002;
localparam [10:0] ST_STRIDE = 11'h004;
localparam [10:0] ST_POS    = 11'h008;
localparam [10:0] ST_SIZE   = 11'h010;
localparam [10:0] ST_KMIN   = 11'h020;
localparam [10:0] ST_KMAX   = 11'h040;
localparam [10:0] ST_KMSK   = 11'h080;
localparam [10:0] ST_SURF   = 11'h100;
localparam [10:0] ST_RDREQ  = 11'h200;
localparam [10:0] ST_RDCAP  = 11'h400;

// Order captured at the taking edge; the port replays it
reg  [10:0] state_reg;
reg  [10:0] state_next;
reg  [31:0] offset_q;
reg  [31:0] stride_q;
reg  [31:0] pos_q;
reg  [31:0] size_q;
reg  [31:0] kmin_q;
reg  [31:0] kmax_q;
reg  [31:0] kmsk_q;
reg  [31:0] surf_q;
reg  [31:0] rb_addr_q;

// Ready straight from state, so a start is seen in the same cycle
assign cmd_ready = (state_reg == ST_IDLE);

////////////////////////////////////////////////////////////////////////////////
// Order checks, before any write reaches the device
wire [31:0] off_pick = cfg_rotate ? cfg_last_pixel_offset : cfg_linear_offset;
wire        off_bad  = cfg_yuv & off_pick[0];
wire [31:0] str_mask = cfg_tiled ? `SPK_STRIDE_TILE_MASK : `SPK_STRIDE_LIN_MASK;
wire        str_bad  = |(cfg_stride & str_mask);
wire        str_big  = cfg_tiled & (cfg_stride > `SPK_STRIDE_TILE_MAX);
wire        dim_zero = (cfg_width == 13'h0000) | (cfg_height == 13'h0000);
wire        wid_odd  = cfg_yuv & cfg_width[0];
// One extra bit so the far edge cannot wrap
wire [13:0] x_end    = {2'b00, cfg_pos_x} + {1'b0, cfg_width};
wire [13:0] y_end    = {2'b00, cfg_pos_y} + {1'b0, cfg_height};
wire        rect_bad = (x_end > {1'b0, cfg_disp_width}) |
                       (y_end > {1'b0, cfg_disp_height});
wire        surf_bad = |cfg_surface_base[`SPK_SURF_LSB-1:0];
wire        any_bad  = off_bad | str_bad | str_big | dim_zero | wid_odd |
                       rect_bad | surf_bad;

////////////////////////////////////////////////////////////////////////////////
// replicate top bits of short channels
function [7:0] spk_fill;
   input [7:0] c;
   input [1:0] low;
   begin
      case (low)
         2'h2:    spk_fill = {c[7:3], c[7:5]};
         2'h3:    spk_fill = {c[7:2], c[7:6]};
         default: spk_fill = c;
      endcase
   end
endfunction

// low bits to replicate per channel
reg  [1:0]  rb_low;
reg  [1:0]  g_low;
always @* begin
   rb_low = 2'h0;
   g_low  = 2'h0;
   case (cfg_low_bits)
      // 5:5:5, three low bits on every channel
      2'h2: begin
         rb_low = 2'h2;
         g_low  = 2'h2;
      end
      // 5:6:5, green keeps six bits so it only loses two
      2'h3: begin
         rb_low = 2'h2;
         g_low  = 2'h3;
      end
      // Code 1 is no short format: keys go out as full bytes
      default: begin
         rb_low = 2'h0;
         g_low  = 2'h0;
      end
   endcase
end

// Upper bound goes out filled the same way as the lower one
wire [23:0] kmin_fill = {spk_fill(cfg_key_lower[23:16], rb_low),
                         spk_fill(cfg_key_lower[15:8], g_low),
                         spk_fill(cfg_key_lower[7:0], rb_low)};
wire [23:0] kmax_fill = {spk_fill(cfg_key_upper[23:16], rb_low),
                         spk_fill(cfg_key_upper[15:8], g_low),
                         spk_fill(cfg_key_upper[7:0], rb_low)};

////////////////////////////////////////////////////////////////////////////////
// Sequence: linear offset first, stride before surface, surface last
always @* begin
   case (state_reg)
      ST_IDLE: begin
         if (cmd_start && !any_bad)
            state_next = ST_LINOFF;
         else if (rb_start && !cmd_start)
            state_next = ST_RDREQ;
         else
            state_next = ST_IDLE;
      end
      ST_LINOFF: state_next = ST_STRIDE;
      ST_STRIDE: state_next = ST_POS;
      ST_POS:    state_next = ST_SIZE;
      ST_SIZE:   state_next = ST_KMIN;
      ST_KMIN:   state_next = ST_KMAX;
      ST_KMAX:   state_next = ST_KMSK;
      ST_KMSK:   state_next = ST_SURF;
      ST_SURF:   state_next = ST_IDLE;
      // Readback: one strobe, then capture
      ST_RDREQ:  state_next = ST_RDCAP;
      ST_RDCAP:  state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs and the device port
always @(posedge mclk) begin
   if (sys_rst) begin
      // Device port idles at zero with strobes low
      state_reg     <= ST_IDLE;
      cmd_done_reg  <= 1'b0;
      cmd_error_reg <= 1'b0;
      rb_valid_reg  <= 1'b0;
      rb_data_reg   <= `SPK_RESET_VALUE;
      dev_addr_reg  <= `SPK_RESET_VALUE;
      dev_wdata_reg <= `SPK_RESET_VALUE;
      dev_wr_reg    <= 1'b0;
      dev_rd_reg    <= 1'b0;
      offset_q      <= `SPK_RESET_VALUE;
      stride_q      <= `SPK_RESET_VALUE;
      pos_q         <= `SPK_RESET_VALUE;
      size_q        <= `SPK_RESET_VALUE;
      kmin_q        <= `SPK_RESET_VALUE;
      kmax_q        <= `SPK_RESET_VALUE;
      kmsk_q        <= `SPK_RESET_VALUE;
      surf_q        <= `SPK_RESET_VALUE;
      rb_addr_q     <= `SPK_RESET_VALUE;
   end else begin
      state_reg     <= state_next;
      cmd_done_reg  <= (state_reg == ST_SURF);
      cmd_error_reg <= cmd_ready & cmd_start & any_bad;
      rb_valid_reg  <= (state_reg == ST_RDCAP);
      // Strobes fall unless a state below raises them again
      dev_wr_reg    <= 1'b0;
      dev_rd_reg    <= 1'b0;
      // Snapshot the order so later cfg changes cannot tear it
      if (state_reg == ST_IDLE && cmd_start && !any_bad) begin
         offset_q <= off_pick;
         stride_q <= cfg_stride;
         pos_q    <= {4'h0, cfg_pos_y, 4'h0, cfg_pos_x};
         size_q   <= {4'h0, cfg_height[11:0] - 12'h001, 4'h0, cfg_width[11:0] - 12'h001};
         kmin_q   <= {8'h00, kmin_fill};
         kmax_q   <= {8'h00, kmax_fill};
         kmsk_q   <= {29'h0, cfg_key_mask};
         surf_q   <= cfg_surface_base;
      end
      // Address copy; the read itself goes out with rb_addr on this same edge
      if (state_reg == ST_IDLE && rb_start && !cmd_start)
         rb_addr_q <= rb_addr;
      // Writes launch on entry to each of the eight write states, one register per cycle
      case (state_next)
         ST_LINOFF: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_LINEAR_OFFSET;
            dev_wdata_reg <= off_pick;
         end
         ST_STRIDE: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_STRIDE;
            dev_wdata_reg <= stride_q;
         end
         ST_POS: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_POSITION;
            dev_wdata_reg <= pos_q;
         end
         ST_SIZE: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_DIMENSIONS;
            dev_wdata_reg <= size_q;
         end
         ST_KMIN: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_KEY_LOWER;
            dev_wdata_reg <= kmin_q;
         end
         ST_KMAX: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_KEY_UPPER;
            dev_wdata_reg <= kmax_q;
         end
         ST_KMSK: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_KEY_MASK;
            dev_wdata_reg <= kmsk_q;
         end
         ST_SURF: begin
            dev_wr_reg    <= 1'b1;
            dev_addr_reg  <= `SPK_OFF_SURFACE_FLIP;
            dev_wdata_reg <= surf_q;
         end
         ST_RDREQ: begin
            dev_rd_reg   <= 1'b1;
            dev_addr_reg <= (state_reg == ST_IDLE) ? rb_addr : rb_addr_q;
         end
         // Address keeps its last value between writes
         default: begin
            dev_addr_reg <= dev_addr_reg;
         end
      endcase
      // Device answers one cycle after the read strobe
      if (state_reg == ST_RDCAP)
         rb_data_reg <= dev_rdata;
   end
end

endmodule

// ===== tb/spkhst_ctrl_asserts.sv
// Port checker for the sprite bank controller.
// Assumes binding onto spkhst_ctrl, one clock.
`timescale 1ns/1ps
`include "spkhst_regs.vh"
module spkhst_ctrl_asserts (
   // Clock, reset and orders
   input logic        mclk,
   input logic        sys_rst,
   input logic        cmd_start,
   input logic        cmd_ready,
   input logic        cmd_done_reg,
   input logic        cmd_error_reg,
   input logic        rb_start,
   input logic [31:0] rb_data_reg,
   input logic        rb_valid_reg,
   // Device port
   input logic [31:0] dev_addr_reg,
   input logic [31:0] dev_wdata_reg,
   input logic        dev_wr_reg,
   input logic        dev_rd_reg,
   input logic [31:0] dev_rdata
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire surf_wr = dev_wr_reg && dev_addr_reg == `SPK_OFF_SURFACE_FLIP;
   wire strd_wr = dev_wr_reg && dev_addr_reg == `SPK_OFF_STRIDE;
   chk_surf_aligned: assert property (
      surf_wr |-> dev_wdata_reg[11:0] == 12'h000) else $error("surface misaligned");
   chk_stride_first: assert property (
      surf_wr |-> $past(strd_wr, 6)) else $error("stride not first");
   chk_stride_low: assert property (
      strd_wr |-> dev_wdata_reg[5:0] == 6'h00) else $error("stride low bits");
   chk_done_flip: assert property (
      cmd_done_reg |-> $past(surf_wr)) else $error("done without flip");
   chk_order_answer: assert property (
      cmd_start && cmd_ready |-> ##1 cmd_error_reg or ##9 cmd_done_reg)
      else $error("order unanswered");
   chk_error_quiet: assert property (
      cmd_error_reg |-> !dev_wr_reg ##1 (!dev_wr_reg && cmd_ready)) else $error("refused wrote");
   chk_rb_latency: assert property (
      rb_start && cmd_ready && !cmd_start |-> ##1 dev_rd_reg ##2 rb_valid_reg)
      else $error("readback late");
   chk_rb_data: assert property (
      rb_valid_reg |-> rb_data_reg == $past(dev_rdata)) else $error("readback data");
   chk_mask_reserved: assert property (
      dev_wr_reg && dev_addr_reg == `SPK_OFF_KEY_MASK |-> dev_wdata_reg[31:3] == 29'h0)
      else $error("mask reserved bits");
endmodule
bind spkhst_ctrl spkhst_ctrl_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .cmd_start(cmd_start), .cmd_ready(cmd_ready), .cmd_done_reg(cmd_done_reg),
   .cmd_error_reg(cmd_error_reg), .rb_start(rb_start), .rb_data_reg(rb_data_reg),
   .rb_valid_reg(rb_valid_reg), .dev_addr_reg(dev_addr_reg), .dev_wdata_reg(dev_wdata_reg),
   .dev_wr_reg(dev_wr_reg), .dev_rd_reg(dev_rd_reg), .dev_rdata(dev_rdata));

// ===== tb/spkhst_dev_model.sv
// Behavioural sprite register bank with pending and active copies.
// Assumes the controller's one-cycle strobe port.
`timescale 1ns/1ps
`include "spkhst_regs.vh"
module spkhst_dev_model (
   // Clock and reset
   input  logic        mclk,
   input  logic        sys_rst,
   // Register port
   input  logic [31:0] dev_addr,
   input  logic [31:0] dev_wdata,
   input  logic        dev_wr,
   input  logic        dev_rd,
   output logic [31:0] dev_rdata,
   // Pipe timing
   input  logic        vblank
);
   logic [31:0] pend [0:7];
   logic [31:0] act [0:7];
   logic [31:0] last_rd;
   logic        armed, vb_d, rd_d;
   wire  [31:0] rel = dev_addr - `SPK_OFF_LINEAR_OFFSET;
   wire         hit = rel[31:5] == 27'h0 && rel[1:0] == 2'h0;
   wire  [31:0] first_px = act[6] + act[0];
   assign dev_rdata = rd_d ? last_rd : ~last_rd;
   always @(posedge mclk) begin
      vb_d <= vblank;
      if (sys_rst) begin
         armed <= 1'b0;
         rd_d <= 1'b0;
         last_rd <= 32'h0;
         for (int i = 0; i < 8; i++) begin
            pend[i] <= 32'h0;
            act[i] <= 32'h0;
         end
      end else begin
         rd_d <= dev_rd;
         if (dev_rd) last_rd <= hit ? pend[rel[4:2]] : 32'h0;
         if (dev_wr && hit) pend[rel[4:2]] <= dev_wdata;
         if (dev_wr && hit && rel[4:2] == 3'h6) armed <= 1'b1;
         if (vblank && !vb_d && armed) begin
            for (int i = 0; i < 8; i++) act[i] <= pend[i];
            armed <= 1'b0;
         end
      end
   end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the sprite bank controller.
// Assumes the device model and the bound checker.
`timescale 1ns/1ps
module tb_top;
   logic        mclk = 0, sys_rst = 1, cmd_start = 0, rb_start = 0, vblank = 0;
   logic        tiled = 0, yuv = 0, rot = 0, dn, er;
   logic [1:0]  low = 0;
   logic [31:0] offs, lpo, strd, surf, rb_addr = 0;
   logic [11:0] px, py;
   logic [12:0] w, h;
   logic [23:0] kl, ku;
   logic [2:0]  km;
   wire  [31:0] rb_data, dev_addr, dev_wdata, dev_rdata;
   wire         cmd_ready, cmd_done, cmd_error, rb_valid, dev_wr, dev_rd;
   int          error_cnt = 0, tests_run = 0;
   always #10 mclk = ~mclk;
   spkhst_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst), .cmd_start(cmd_start),
      .cmd_ready(cmd_ready), .cmd_done_reg(cmd_done), .cmd_error_reg(cmd_error),
      .cfg_tiled(tiled), .cfg_yuv(yuv), .cfg_low_bits(low), .cfg_rotate(rot),
      .cfg_linear_offset(offs), .cfg_last_pixel_offset(lpo), .cfg_stride(strd),
      .cfg_pos_x(px), .cfg_pos_y(py), .cfg_width(w), .cfg_height(h),
      .cfg_disp_width(13'h0780), .cfg_disp_height(13'h0438), .cfg_key_lower(kl),
      .cfg_key_upper(ku), .cfg_key_mask(km), .cfg_surface_base(surf),
      .rb_start(rb_start), .rb_addr(rb_addr), .rb_data_reg(rb_data),
      .rb_valid_reg(rb_valid), .dev_addr_reg(dev_addr), .dev_wdata_reg(dev_wdata),
      .dev_wr_reg(dev_wr), .dev_rd_reg(dev_rd), .dev_rdata(dev_rdata));
   spkhst_dev_model u_dev (.mclk(mclk), .sys_rst(sys_rst), .dev_addr(dev_addr),
      .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
      .vblank(vblank));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task good;
      {tiled, yuv, rot, low, offs, lpo, strd} = {5'h0, 32'h1000, 32'h2000, 32'h200};
      {px, py, w, h} = {12'h010, 12'h020, 13'h0100, 13'h0080};
      {kl, ku, km, surf} = {24'h102030, 24'h405060, 3'h5, 32'h0012_3000};
   endtask
   task run_cmd;
      @(negedge mclk) cmd_start = 1;
      @(negedge mclk) cmd_start = 0;
      {dn, er} = {cmd_done, cmd_error};
      for (int n = 0; n < 12 && !dn && !er; n++) begin
         @(posedge mclk) #1;
         {dn, er} = {cmd_done, cmd_error};
      end
   endtask
   task rb_read(input logic [31:0] a, input logic [31:0] exp);
      @(negedge mclk) {rb_addr, rb_start} = {a, 1'b1};
      @(negedge mclk) rb_start = 0;
      for (int n = 0; n < 6 && rb_valid !== 1'b1; n++) @(posedge mclk) #1;
      check(rb_data, exp);
   endtask
   task t_program;
      good();
      run_cmd();
      check(dn, 1);
      check(u_dev.pend[1], 32'h200);
      check(u_dev.pend[2], 32'h0020_0010);
      check(u_dev.pend[3], 32'h007f_00ff);
      check(u_dev.pend[4], 32'h0010_2030);
      check(u_dev.pend[5], 32'h5);
      check(u_dev.pend[7], 32'h0040_5060);
      check(u_dev.act[0], 32'h0);
      @(negedge mclk) vblank = 1;
      @(negedge mclk) vblank = 0;
      check(u_dev.act[6], 32'h0012_3000);
      rb_read(32'h0007_2188, 32'h200);
      rb_read(32'h0007_2300, 32'h0);
   endtask
   task t_refuse;
      for (int k = 0; k < 7; k++) begin
         good();
         case (k)
            0: {yuv, offs} = {1'b1, 32'h1001};
            1: strd = 32'h220;
            2: {tiled, strd} = {1'b1, 32'h240};
            3: {tiled, strd} = {1'b1, 32'h8000};
            4: px = 12'h700;
            5: {yuv, w} = {1'b1, 13'h0101};
            default: surf = 32'h0012_3800;
         endcase
         run_cmd();
         check({dn, er}, 2'b01);
      end
   endtask
   task t_variants;
      good();
      {tiled, strd, rot, low, kl} = {1'b1, 32'h4000, 1'b1, 2'h2, 24'ha8a8a8};
      run_cmd();
      check(dn, 1);
      check(u_dev.pend[0], 32'h2000);
      check(u_dev.pend[4], 32'h00ad_adad);
      {yuv, low} = {1'b1, 2'h3};
      run_cmd();
      check(u_dev.pend[4], 32'h00ad_aaad);
   endtask
   initial begin
      good();
      repeat (2) @(posedge mclk);
      @(negedge mclk) sys_rst = 0;
      t_program();
      t_refuse();
      t_variants();
      results();
   end
   initial begin
      #100000;
      error_cnt++;
      results();
   end
endmodule
